// ### pkg/rrc_pkg.sv
/*
 * Shared constants and BCD helpers for the reversible ring counter block.
 * Assumes a 32-bit classic Wishbone bus with byte addressing.
 */
package rrc_pkg;
    localparam int          NCNT       = 11;
    localparam int          DM_DEPTH   = 1024;
    localparam logic [15:0] BCD_ZERO   = 16'h0000;
    localparam logic [15:0] BCD_MAX    = 16'h9999;
    localparam int          RNG_BITS   = 8;
    localparam int          WORD_BITS  = 16;
    // Byte addresses of the register map.
    localparam logic [15:0] A_CCTRL    = 16'h0000;
    localparam logic [15:0] A_CSV      = 16'h0004;
    localparam logic [15:0] A_CSTAT    = 16'h0008;
    localparam logic [15:0] A_SCAN     = 16'h000c;
    localparam logic [15:0] A_STATUS   = 16'h0010;
    localparam logic [15:0] A_DEXEC    = 16'h0014;
    localparam logic [15:0] A_AUXRST   = 16'h0018;
    localparam logic [15:0] A_AUXDIR   = 16'h001c;
    localparam logic [15:0] A_DEN      = 16'h0020;
    localparam logic [15:0] A_TBASE    = 16'h0040;
    localparam logic [15:0] A_RBASE    = 16'h0080;
    localparam logic [15:0] A_DPV      = 16'h00c0;
    localparam logic [15:0] A_DM       = 16'h1000;
    localparam logic [15:0] A_DM_END   = 16'h2000;
    localparam logic [15:0] A_ARR_SPAN = 16'h0040;
    // Field positions.
    localparam int          B_INC      = 0;
    localparam int          B_DEC      = 1;
    localparam int          B_RST      = 2;
    localparam int          B_GO       = 0;
    localparam int          B_ERR      = 0;
    localparam int          B_DONE     = 16;

    function automatic logic [15:0] bcd_inc(input logic [15:0] v);
        logic [15:0] r;
        logic        c;
        r = v;
        c = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (c)
            begin
                if (r[4*i +: 4] >= 4'h9)
                    r[4*i +: 4] = 4'h0;
                else
                begin
                    r[4*i +: 4] = r[4*i +: 4] + 4'h1;
                    c = 1'b0;
                end
            end
        end
        return r;
    endfunction

    function automatic logic [15:0] bcd_dec(input logic [15:0] v);
        logic [15:0] r;
        logic        b;
        r = v;
        b = 1'b1;
        for (int i = 0; i < 4; i++)
        begin
            if (b)
            begin
                if (r[4*i +: 4] == 4'h0)
                    r[4*i +: 4] = 4'h9;
                else
                begin
                    r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                    b = 1'b0;
                end
            end
        end
        return r;
    endfunction

    function automatic logic bcd_ok(input logic [15:0] v);
        logic ok;
        ok = 1'b1;
        for (int i = 0; i < 4; i++)
            if (v[4*i +: 4] > 4'h9)
                ok = 1'b0;
        return ok;
    endfunction
endpackage

// ### rtl/rrc_drum.sv
/*
 * One reversible drum counter, 0 to 9999 in BCD, evaluated once per scan.
 * Assumes scan_in is a one-cycle pulse and the other inputs are same-clock.
 */
`timescale 1ns/1ps
`default_nettype none
module rrc_drum (
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        scan_in,
    input  wire logic        exec_in,
    input  wire logic        reset_bit_in,
    input  wire logic        dir_in,
    output logic      [15:0] pv_out
);
    typedef struct packed {
        logic [15:0] pv;
        logic        exec_prev;
    } rrc_drum_t;

    rrc_drum_t s_r;
    rrc_drum_t s_nxt;

    always_comb
    begin
        s_nxt = s_r;
        if (scan_in)
        begin
            // (RULE24) Edge memory per scan.
            s_nxt.exec_prev = exec_in;
            // (RULE18) Held at zero.
            if (reset_bit_in)
                s_nxt.pv = rrc_pkg::BCD_ZERO;
            // (RULE11) Count on rising edge.
            else if (exec_in && !s_r.exec_prev)
            begin
                // (RULE19) Direction bit selects.
                if (dir_in)
                    s_nxt.pv = rrc_pkg::bcd_dec(s_r.pv);
                else
                    s_nxt.pv = rrc_pkg::bcd_inc(s_r.pv);
            end
        end
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    assign pv_out = s_r.pv;

    property p_drum_hold;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        scan_in && reset_bit_in |=> s_r.pv == rrc_pkg::BCD_ZERO;
    endproperty
    a_drum_hold: assert property (p_drum_hold) // (RULE18)
        else $error("drum counter not held at zero");

    property p_drum_wrap;
        @(posedge core_clk_in) disable iff (!arst_n_in)
        scan_in && !reset_bit_in && exec_in && !s_r.exec_prev && !dir_in
            && s_r.pv == rrc_pkg::BCD_MAX |=> s_r.pv == rrc_pkg::BCD_ZERO;
    endproperty
    a_drum_wrap: assert property (p_drum_wrap) // (RULE11)
        else $error("drum counter did not wrap 9999 to 0");
endmodule
`default_nettype wire

// ### rtl/rrc_top.sv
/*
 * Reversible ring counters: one circular up/down counter and eleven drum
 * counters with range tables in an internal data memory, on Wishbone.
 * Assumes a classic Wishbone master on core_clk_in and software scans.
 */
// Behaviour
// (RULE1) Circular value stays within zero and set value, moved only by inputs.
// (RULE2) Increment input rising since last scan adds one.
// (RULE3) Decrement input rising since last scan subtracts one.
// (RULE4) Both or neither rising leaves the value unchanged.
// (RULE5) Decrement from zero loads set value, raises done until next decrement; in the code the next increment wraps to zero and raises done again.
// (RULE6) Increment past set value loads zero, raises done until next increment; in the code the next decrement reloads the set value and raises done again.
// (RULE7) Reset clears value to zero; no counting while reset is on.
// (RULE8) Value is kept; only reset input or power-up reset clears it.
// (RULE9) Non-BCD set value raises the error flag without stopping.
// (RULE10) Only drum counters 500 to 510 exist, indices zero to ten.
// (RULE11) Drum counter rings 0 to 9999, one step per input rising edge.
// (RULE12) Base word bits 0 to 7 hold ranges minus one.
// (RULE13) Ranges are word pairs after base; lower bound first unless wrapping.
// (RULE14) Value in range k sets result bit k, sixteen per result word.
// (RULE15) Results refreshed during reset using a value of zero.
// (RULE16) Table edits take effect on the next comparison.
// (RULE17) Each drum owns a reset and direction bit, by number minus 500.
// (RULE18) Drum held at zero while its reset bit is on.
// (RULE19) Direction bit on counts down, off counts up.
// (RULE20) Error when base and next two words leave the data memory.
// (RULE21) Software keeps table words BCD; no error is raised for them.
// (RULE22) Error when an addressed table or result word is out of memory.
// (RULE23) Software avoids driving counts from fast clock pulse bits.
// (RULE24) Inputs are evaluated only on a scan strobe, with edge memory.
`timescale 1ns/1ps
`default_nettype none
module rrc_top #(
    parameter int NCNT     = rrc_pkg::NCNT,
    parameter int DM_WORDS = rrc_pkg::DM_DEPTH
) (
    input  wire logic        core_clk_in,
    input  wire logic        arst_n_in,
    input  wire logic        wb_cyc_in,
    input  wire logic        wb_stb_in,
    input  wire logic        wb_we_in,
    input  wire logic [15:0] wb_adr_in,
    input  wire logic [3:0]  wb_sel_in,
    input  wire logic [31:0] wb_dat_in,
    output logic      [31:0] wb_dat_out,
    output logic             wb_ack_out,
    output logic      [15:0] circ_pv_out,
    output logic             circ_done_out,
    output logic             error_flag_out
);
    localparam int AW = $clog2(DM_WORDS);
    localparam int XW = AW + 2;

    typedef enum logic [1:0] {
        S_IDLE  = 2'b00,
        S_HEAD  = 2'b01,
        S_RANGE = 2'b10,
        S_NEXT  = 2'b11
    } rrc_seq_t;

    typedef struct packed {
        logic                      ack;
        logic [31:0]               dat;
        logic [2:0]                cctrl;
        logic [15:0]               csv;
        logic [15:0]               cpv;
        logic                      cdone;
        logic                      inc_prev;
        logic                      dec_prev;
        logic                      err;
        logic [NCNT-1:0]           dexec;
        logic [NCNT-1:0]           aux_rst;
        logic [NCNT-1:0]           aux_dir;
        logic [NCNT-1:0]           den;
        logic [NCNT-1:0][AW-1:0]   tbase;
        logic [NCNT-1:0][AW-1:0]   rbase;
        rrc_seq_t                  st;
        logic [3:0]                k;
        logic [7:0]                n;
        logic [8:0]                j;
        logic [15:0]               acc;
    } rrc_state_t;

    rrc_state_t s_r;
    rrc_state_t s_nxt;

    // The table memory has no reset: its contents belong to software.
    logic [15:0] dm_mem [DM_WORDS];

    logic                  req;
    logic                  wr;
    logic                  is_dm;
    logic [AW-1:0]         dm_idx;
    logic [3:0]            arr_idx;
    logic                  scan_go;
    logic                  inc_rise;
    logic                  dec_rise;
    logic [NCNT-1:0][15:0] dpv;
    logic                  seq_we;
    logic [AW-1:0]         seq_wa;
    logic [15:0]           seq_wd;
    logic [XW-1:0]         a_lo;
    logic [XW-1:0]         a_hi;
    logic [XW-1:0]         a_res;
    logic [15:0]           lo_w;
    logic [15:0]           hi_w;
    logic [15:0]           cmp_pv;
    logic                  hit;
    logic [15:0]           acc_new;
    logic [31:0]           wdat;
    logic [31:0]           rdat;
    logic                  clr_err;
    logic                  set_err;

    assign req     = wb_cyc_in && wb_stb_in;
    // Data memory access waits while the sequencer owns the memory.
    assign is_dm   = wb_adr_in >= rrc_pkg::A_DM && wb_adr_in < rrc_pkg::A_DM_END;
    assign dm_idx  = AW'(wb_adr_in[15:2]);
    assign arr_idx = wb_adr_in[5:2];
    assign wr      = req && wb_we_in && s_r.ack;
    assign wdat    = {wb_sel_in[3] ? wb_dat_in[31:24] : 8'h00,
                      wb_sel_in[2] ? wb_dat_in[23:16] : 8'h00,
                      wb_sel_in[1] ? wb_dat_in[15:8]  : 8'h00,
                      wb_sel_in[0] ? wb_dat_in[7:0]   : 8'h00};

    // A scan is refused while the previous table walk is still running.
    assign scan_go = wr && wb_adr_in == rrc_pkg::A_SCAN
                     && wdat[rrc_pkg::B_GO] && s_r.st == S_IDLE;
    // (RULE24) Rising edges since last scan.
    assign inc_rise = s_r.cctrl[rrc_pkg::B_INC] && !s_r.inc_prev;
    assign dec_rise = s_r.cctrl[rrc_pkg::B_DEC] && !s_r.dec_prev;

    genvar g;
    generate
        for (g = 0; g < NCNT; g++)
        begin : g_drum
            // (RULE17) Bit index is number minus 500.
            rrc_drum u_drum (
                .core_clk_in  (core_clk_in),
                .arst_n_in    (arst_n_in),
                .scan_in      (scan_go && s_r.den[g]),
                .exec_in      (s_r.dexec[g]),
                .reset_bit_in (s_r.aux_rst[g]),
                .dir_in       (s_r.aux_dir[g]),
                .pv_out       (dpv[g])
            );
        end
    endgenerate

    // (RULE13) Pair j sits at base plus one plus twice j.
    assign a_lo   = XW'(s_r.tbase[s_r.k]) + XW'(1) + XW'({s_r.j, 1'b0});
    assign a_hi   = a_lo + XW'(1);
    assign a_res  = XW'(s_r.rbase[s_r.k]) + XW'(s_r.j[8:4]);
    assign lo_w   = dm_mem[AW'(a_lo)];
    assign hi_w   = dm_mem[AW'(a_hi)];
    // (RULE15) Reset bit forces zero.
    assign cmp_pv = s_r.aux_rst[s_r.k] ? rrc_pkg::BCD_ZERO : dpv[s_r.k];
    // (RULE13) Wrapping range spans zero.
    assign hit = (lo_w <= hi_w) ? (cmp_pv >= lo_w && cmp_pv <= hi_w)
                                : (cmp_pv >= lo_w || cmp_pv <= hi_w);
    // (RULE14) Bit j, modulo sixteen, of the result word.
    assign acc_new = s_r.acc | (16'(hit) << s_r.j[3:0]);
    assign seq_we  = s_r.st == S_RANGE && a_hi < XW'(DM_WORDS)
                     && a_res < XW'(DM_WORDS)
                     && (s_r.j[3:0] == 4'hf || s_r.j[7:0] == s_r.n);
    assign seq_wa  = AW'(a_res);
    assign seq_wd  = acc_new;

    always_comb
    begin
        rdat = 32'h0000_0000;
        if (is_dm)
            rdat = {16'h0000, dm_mem[dm_idx]};
        else if (wb_adr_in >= rrc_pkg::A_TBASE && wb_adr_in < rrc_pkg::A_RBASE)
            rdat = (arr_idx < 4'(NCNT)) ? 32'(s_r.tbase[arr_idx]) : 32'h0;
        else if (wb_adr_in >= rrc_pkg::A_RBASE && wb_adr_in < rrc_pkg::A_DPV)
            rdat = (arr_idx < 4'(NCNT)) ? 32'(s_r.rbase[arr_idx]) : 32'h0;
        else if (wb_adr_in >= rrc_pkg::A_DPV
                 && wb_adr_in < rrc_pkg::A_DPV + rrc_pkg::A_ARR_SPAN)
            rdat = (arr_idx < 4'(NCNT)) ? 32'(dpv[arr_idx]) : 32'h0;
        else
        begin
            case (wb_adr_in)
                rrc_pkg::A_CCTRL:  rdat = 32'(s_r.cctrl);
                rrc_pkg::A_CSV:    rdat = 32'(s_r.csv);
                rrc_pkg::A_CSTAT:  rdat = {15'h0000, s_r.cdone, s_r.cpv};
                rrc_pkg::A_SCAN:   rdat = 32'(s_r.st != S_IDLE);
                rrc_pkg::A_STATUS: rdat = 32'(s_r.err);
                rrc_pkg::A_DEXEC:  rdat = 32'(s_r.dexec);
                rrc_pkg::A_AUXRST: rdat = 32'(s_r.aux_rst);
                rrc_pkg::A_AUXDIR: rdat = 32'(s_r.aux_dir);
                rrc_pkg::A_DEN:    rdat = 32'(s_r.den);
                default:           rdat = 32'h0000_0000;
            endcase
        end
    end

    always_comb
    begin
        s_nxt   = s_r;
        set_err = 1'b0;
        clr_err = wr && wb_adr_in == rrc_pkg::A_STATUS && wdat[rrc_pkg::B_ERR];
        s_nxt.ack = req && !s_r.ack && !(is_dm && s_r.st != S_IDLE);
        if (s_nxt.ack)
            s_nxt.dat = rdat;
        if (wr)
        begin
            if (wb_adr_in >= rrc_pkg::A_TBASE && wb_adr_in < rrc_pkg::A_RBASE
                && arr_idx < 4'(NCNT))
                s_nxt.tbase[arr_idx] = AW'(wdat);
            if (wb_adr_in >= rrc_pkg::A_RBASE && wb_adr_in < rrc_pkg::A_DPV
                && arr_idx < 4'(NCNT))
                s_nxt.rbase[arr_idx] = AW'(wdat);
            case (wb_adr_in)
                rrc_pkg::A_CCTRL:  s_nxt.cctrl   = wdat[2:0];
                rrc_pkg::A_CSV:    s_nxt.csv     = wdat[15:0];
                rrc_pkg::A_DEXEC:  s_nxt.dexec   = wdat[NCNT-1:0];
                rrc_pkg::A_AUXRST: s_nxt.aux_rst = wdat[NCNT-1:0];
                rrc_pkg::A_AUXDIR: s_nxt.aux_dir = wdat[NCNT-1:0];
                rrc_pkg::A_DEN:    s_nxt.den     = wdat[NCNT-1:0];
                default:           s_nxt.st      = s_nxt.st;
            endcase
        end
        if (scan_go)
        begin
            // (RULE24) Edge memory per scan.
            s_nxt.inc_prev = s_r.cctrl[rrc_pkg::B_INC];
            s_nxt.dec_prev = s_r.cctrl[rrc_pkg::B_DEC];
            // (RULE9) Bad set value flagged.
            if (!rrc_pkg::bcd_ok(s_r.csv))
                set_err = 1'b1;
            // (RULE7) Reset clears, blocks counting.
            if (s_r.cctrl[rrc_pkg::B_RST])
            begin
                s_nxt.cpv   = rrc_pkg::BCD_ZERO;
                s_nxt.cdone = 1'b0;
            end
            // (RULE2) Single increment edge.
            else if (inc_rise && !dec_rise)
            begin
                // (RULE6) Past set value wraps.
                if (s_r.cpv >= s_r.csv)
                begin
                    s_nxt.cpv   = rrc_pkg::BCD_ZERO;
                    s_nxt.cdone = 1'b1;
                end
                else
                begin
                    s_nxt.cpv   = rrc_pkg::bcd_inc(s_r.cpv);
                    s_nxt.cdone = 1'b0;
                end
            end
            // (RULE3) Single decrement edge.
            else if (dec_rise && !inc_rise)
            begin
                // (RULE5) Below zero loads limit.
                if (s_r.cpv == rrc_pkg::BCD_ZERO)
                begin
                    s_nxt.cpv   = s_r.csv;
                    s_nxt.cdone = 1'b1;
                end
                else
                begin
                    s_nxt.cpv   = rrc_pkg::bcd_dec(s_r.cpv);
                    s_nxt.cdone = 1'b0;
                end
            end
            // (RULE4) Both or neither: hold.
            s_nxt.st = S_HEAD;
            s_nxt.k  = 4'h0;
        end
        case (s_r.st)
            S_IDLE:
                s_nxt.j = s_nxt.j;
            S_HEAD:
            begin
                s_nxt.j   = 9'h000;
                s_nxt.acc = 16'h0000;
                s_nxt.st  = S_NEXT;
                if (s_r.den[s_r.k])
                begin
                    // (RULE20) Base and two words inside.
                    if (XW'(s_r.tbase[s_r.k]) + XW'(2) >= XW'(DM_WORDS))
                        set_err = 1'b1;
                    else
                    begin
                        // (RULE12) Range count minus one.
                        s_nxt.n  = dm_mem[s_r.tbase[s_r.k]][rrc_pkg::RNG_BITS-1:0];
                        s_nxt.st = S_RANGE;
                    end
                end
            end
            S_RANGE:
            begin
                // (RULE22) Out-of-memory word ends this counter's walk.
                if (a_hi >= XW'(DM_WORDS) || a_res >= XW'(DM_WORDS))
                begin
                    set_err  = 1'b1;
                    s_nxt.st = S_NEXT;
                end
                else
                begin
                    // (RULE14) Spill to next word.
                    s_nxt.acc = seq_we ? 16'h0000 : acc_new;
                    if (s_r.j[7:0] == s_r.n)
                        s_nxt.st = S_NEXT;
                    else
                        s_nxt.j = s_r.j + 9'h001;
                end
            end
            S_NEXT:
            begin
                if (s_r.k == 4'(NCNT - 1))
                    s_nxt.st = S_IDLE;
                else
                begin
                    s_nxt.k  = s_r.k + 4'h1;
                    s_nxt.st = S_HEAD;
                end
            end
            default:
                s_nxt.st = S_IDLE;
        endcase
        // Set wins over a clear in the same cycle.
        s_nxt.err = set_err || (s_r.err && !clr_err);
    end

    always_ff @(posedge core_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
            s_r <= '0;
        else
            s_r <= s_nxt;
    end

    // (RULE16) Table read live each walk.
    always_ff @(posedge core_clk_in)
    begin
        if (seq_we)
            dm_mem[seq_wa] <= seq_wd;
        else if (wr && is_dm)
            dm_mem[dm_idx] <= wdat[rrc_pkg::WORD_BITS-1:0];
    end

    // (RULE8) Cleared only by reset paths.
    assign circ_pv_out    = s_r.cpv;
    assign circ_done_out  = s_r.cdone;
    assign error_flag_out = s_r.err;
    assign wb_ack_out     = s_r.ack;
    assign wb_dat_out     = s_r.dat;

    default clocking cb @(posedge core_clk_in);
    endclocking
    default disable iff (!arst_n_in);

    logic plain_scan;
    assign plain_scan = scan_go && !s_r.cctrl[rrc_pkg::B_RST];

    property p_inc;
        plain_scan && inc_rise && !dec_rise && s_r.cpv < s_r.csv
        |=> s_r.cpv == rrc_pkg::bcd_inc($past(s_r.cpv)) && !s_r.cdone;
    endproperty
    a_inc: assert property (p_inc) // (RULE2)
        else $error("increment did not add one");
    property p_dec;
        plain_scan && dec_rise && !inc_rise && s_r.cpv != rrc_pkg::BCD_ZERO
        |=> s_r.cpv == rrc_pkg::bcd_dec($past(s_r.cpv));
    endproperty
    a_dec: assert property (p_dec) // (RULE3)
        else $error("decrement did not subtract one");
    property p_hold;
        plain_scan && (inc_rise == dec_rise) |=> $stable(s_r.cpv);
    endproperty
    a_hold: assert property (p_hold) // (RULE4)
        else $error("value changed without a single edge");
    property p_dwrap;
        plain_scan && dec_rise && !inc_rise && s_r.cpv == rrc_pkg::BCD_ZERO
        |=> s_r.cpv == $past(s_r.csv) && circ_done_out;
    endproperty
    a_dwrap: assert property (p_dwrap) // (RULE5)
        else $error("decrement from zero did not load limit");
    property p_iwrap;
        plain_scan && inc_rise && !dec_rise && s_r.cpv >= s_r.csv
        |=> s_r.cpv == rrc_pkg::BCD_ZERO && circ_done_out;
    endproperty
    a_iwrap: assert property (p_iwrap) // (RULE6)
        else $error("increment past limit did not wrap");
    property p_rst;
        scan_go && s_r.cctrl[rrc_pkg::B_RST] |=> circ_pv_out == 16'h0000;
    endproperty
    a_rst: assert property (p_rst) // (RULE7)
        else $error("reset input did not clear value");
    property p_keep;
        !scan_go |=> $stable(circ_pv_out) && $stable(circ_done_out);
    endproperty
    a_keep: assert property (p_keep) // (RULE8)
        else $error("value changed outside a scan");
    property p_svbad;
        scan_go && !rrc_pkg::bcd_ok(s_r.csv) |=> error_flag_out;
    endproperty
    a_svbad: assert property (p_svbad) // (RULE9)
        else $error("bad set value not flagged");
    property p_spill;
        seq_we |-> s_r.j[3:0] == 4'hf || s_r.j[7:0] == s_r.n;
    endproperty
    a_spill: assert property (p_spill) // (RULE14)
        else $error("result word written mid-word");

    c_iwrap: cover property (plain_scan && inc_rise && s_r.cpv >= s_r.csv);
    c_dwrap: cover property (plain_scan && dec_rise && s_r.cpv == 16'h0000);
    c_write: cover property (seq_we && hit);
    c_err:   cover property (set_err);
endmodule
`default_nettype wire

// ### tb/tb.sv
/*
 * Self-checking bench for rrc_top: circular counter, drum counter, errors.
 * Assumes rrc_pkg and the design files are compiled ahead of it.
 */
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) \
    begin \
        compares++; \
        if ((a) !== (e)) \
        begin \
            n_fail++; \
            $display("MISMATCH t=%0t got=%h exp=%h", $time, a, e); \
        end \
    end
module tb;
    localparam logic [31:0] D10 = 32'h0000_0400;
    logic        clk;
    logic        rst_n;
    logic        cyc;
    logic        stb;
    logic        we;
    logic [15:0] adr;
    logic [31:0] wdat;
    logic [31:0] rdat;
    logic [31:0] q;
    logic        ack;
    logic [15:0] pv;
    logic        done;
    logic        err;
    int          n_fail;
    int          compares;

    rrc_top #(.DM_WORDS(64)) u_dut (
        .core_clk_in    (clk),
        .arst_n_in      (rst_n),
        .wb_cyc_in      (cyc),
        .wb_stb_in      (stb),
        .wb_we_in       (we),
        .wb_adr_in      (adr),
        .wb_sel_in      (4'hf),
        .wb_dat_in      (wdat),
        .wb_dat_out     (rdat),
        .wb_ack_out     (ack),
        .circ_pv_out    (pv),
        .circ_done_out  (done),
        .error_flag_out (err)
    );

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    task automatic close_out;
        $display("compares=%0d n_fail=%0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // Called at a rising edge; the request is held until ack is seen.
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        int i;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        for (i = 0; i < 400; i++)
        begin
            @(posedge clk);
            if (ack === 1'b1)
                break;
        end
        if (ack !== 1'b1)
        begin
            n_fail++;
            close_out;
        end
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    endtask

    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        wb(1'b1, a, d);
    endtask

    task automatic ck(input logic [15:0] a, input logic [31:0] e);
        wb(1'b0, a, 32'h0);
        `CHK(q, e)
    endtask

    // The walk length varies, so busy is polled under a bound.
    task automatic scan;
        int j;
        wr(rrc_pkg::A_SCAN, 32'h1);
        j = 0;
        do
        begin
            wb(1'b0, rrc_pkg::A_SCAN, 32'h0);
            j++;
        end
        while (q[0] !== 1'b0 && j < 50);
        `CHK(q[0], 1'b0)
        if (q[0] !== 1'b0)
            close_out;
    endtask

    // Count edges come only from explicit register writes.

    task automatic pulse(input logic [15:0] a, input logic [31:0] v);
        wr(a, v);
        scan;
        wr(a, 32'h0);
        scan;
    endtask

    initial
    begin
        logic [15:0] tbl [5] = '{16'h1, 16'h1, 16'h2, 16'h9998, 16'h1};
        n_fail = 0;
        compares = 0;
        rst_n = 1'b0;
        cyc = 1'b0;
        stb = 1'b0;
        we = 1'b0;
        adr = 16'h0;
        wdat = 32'h0;
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        wr(rrc_pkg::A_CSV, 32'h10);
        for (int i = 1; i <= 11; i++)
        begin
            pulse(rrc_pkg::A_CCTRL, 32'h1);
            ck(rrc_pkg::A_CSTAT, (i == 11) ? 32'h1_0000
               : 32'((i / 10) * 16 + i % 10));
        end
        pulse(rrc_pkg::A_CCTRL, 32'h2);
        ck(rrc_pkg::A_CSTAT, 32'h1_0010);
        pulse(rrc_pkg::A_CCTRL, 32'h2);
        ck(rrc_pkg::A_CSTAT, 32'h9);
        pulse(rrc_pkg::A_CCTRL, 32'h3);
        ck(rrc_pkg::A_CSTAT, 32'h9);
        `CHK(pv, 16'h9)
        wr(rrc_pkg::A_CCTRL, 32'h4);
        scan;
        pulse(rrc_pkg::A_CCTRL, 32'h5);
        ck(rrc_pkg::A_CSTAT, 32'h0);
        $display("test circular done");
        wr(rrc_pkg::A_CSV, 32'ha0);
        scan;
        ck(rrc_pkg::A_STATUS, 32'h1);
        `CHK(err, 1'b1)
        wr(rrc_pkg::A_CSV, 32'h10);
        wr(rrc_pkg::A_STATUS, 32'h1);
        ck(rrc_pkg::A_STATUS, 32'h0);
        $display("test error done");
        // Table words are all valid BCD.
        for (int i = 0; i < 5; i++)
            wr(rrc_pkg::A_DM + 16'(4 * i), 32'(tbl[i]));
        wr(rrc_pkg::A_TBASE + 16'h28, 32'h0);
        wr(rrc_pkg::A_RBASE + 16'h28, 32'ha);
        wr(rrc_pkg::A_DEN, D10);
        scan;
        ck(rrc_pkg::A_DM + 16'h28, 32'h2);
        pulse(rrc_pkg::A_DEXEC, D10);
        ck(rrc_pkg::A_DPV + 16'h28, 32'h1);
        ck(rrc_pkg::A_DM + 16'h28, 32'h3);
        wr(rrc_pkg::A_AUXDIR, D10);
        pulse(rrc_pkg::A_DEXEC, D10);
        pulse(rrc_pkg::A_DEXEC, D10);
        ck(rrc_pkg::A_DPV + 16'h28, 32'h9999);
        ck(rrc_pkg::A_DM + 16'h28, 32'h2);
        wr(rrc_pkg::A_DM + 16'hc, 32'h0);
        scan;
        ck(rrc_pkg::A_DM + 16'h28, 32'h0);
        wr(rrc_pkg::A_AUXRST, D10);
        pulse(rrc_pkg::A_DEXEC, D10);
        ck(rrc_pkg::A_DPV + 16'h28, 32'h0);
        ck(rrc_pkg::A_DM + 16'h28, 32'h2);
        wr(rrc_pkg::A_TBASE + 16'h28, 32'h3e);
        scan;
        ck(rrc_pkg::A_STATUS, 32'h1);
        ck(16'h0300, 32'h0);
        $display("test drum done");
        close_out;
    end
endmodule
`default_nettype wire
